// ---- kds_cfg.svh ----
// constants for the keyboard display scanner
`ifndef KDS_CFG_SVH
`define KDS_CFG_SVH
`define KDS_PRESCALE_RST 5'h1f
`define KDS_PRESCALE_MIN 5'h02
`define KDS_KEYMODE_RST 3'h0
`define KDS_DISPMODE_RST 2'h1
`define KDS_CMD_MODE 3'h0
`define KDS_CMD_CLOCK 3'h1
`define KDS_CMD_RDFIFO 3'h2
`define KDS_CMD_RDDISP 3'h3
`define KDS_CMD_WRDISP 3'h4
`define KDS_CMD_BLANK 3'h5
`define KDS_CMD_CLEAR 3'h6
`define KDS_CMD_ENDINT 3'h7
`define KDS_FIFO_DEPTH 8
`define KDS_DEBOUNCE_SCANS 4'h2
`define KDS_CLEAR_PAT 8'h20
`endif

// ---- kds_pkg.sv ----
// types for the keyboard display scanner
package kds_pkg;
    typedef enum logic [1:0] {
        KDS_KEY_LOCK = 2'h0,
        KDS_KEY_ROLL = 2'h1,
        KDS_SENSOR = 2'h2,
        KDS_STROBED = 2'h3
    } kds_kmode_t;
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic cmd_data_sel;
    } kds_bus_t;
    typedef struct packed {
        logic [3:0] scan_outputs;
        logic [3:0] disp_nibble_a;
        logic [3:0] disp_nibble_b;
        logic blank_display_n;
    } kds_disp_t;
endpackage : kds_pkg

// ---- kds_scanner.sv ----
// keyboard display scanner device logic
`timescale 1ns/1ns
`include "kds_cfg.svh"
module kds_scanner #(
    parameter int DEPTH = `KDS_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reset_in,
    input wire kds_pkg::kds_bus_t bus_in,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic [7:0] return_lines,
    input wire logic shift_in,
    input wire logic ctrl_strobe_in,
    output logic irq_out,
    output kds_pkg::kds_disp_t disp_out,
    output logic underrun_flag,
    output logic overrun_flag
);
    initial begin
        if (DEPTH != 8) $error("fifo depth must be 8");
    end
    // synchronisers for pins
    kds_pkg::kds_bus_t bus_s1_r, bus_r;
    logic [7:0] ret_s1_r, ret_r, din_s1_r, din_r;
    logic shf_s1_r, shf_r, ctl_s1_r, ctl_r, ctl_d_r, rst_s1_r, rst_r;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus_s1_r <= '1;
            bus_r <= '1;
            ret_s1_r <= 8'hff;
            ret_r <= 8'hff;
            din_s1_r <= 8'h00;
            din_r <= 8'h00;
            {shf_s1_r, shf_r, ctl_s1_r, ctl_r, ctl_d_r} <= 5'h00;
            {rst_s1_r, rst_r} <= 2'h3;
        end else begin
            bus_s1_r <= bus_in;
            bus_r <= bus_s1_r;
            ret_s1_r <= return_lines;
            ret_r <= ret_s1_r;
            din_s1_r <= host_data_in;
            din_r <= din_s1_r;
            {shf_s1_r, shf_r} <= {shift_in, shf_s1_r};
            {ctl_s1_r, ctl_r, ctl_d_r} <= {ctrl_strobe_in, ctl_s1_r, ctl_r};
            {rst_s1_r, rst_r} <= {reset_in, rst_s1_r};
        end
    end
    // host strobes, edges of the synchronised levels
    logic wr_d_r, rd_d_r;
    wire sel = !bus_r.cs_n;
    wire wr_rise = sel && !wr_d_r && bus_r.wr_n;
    wire rd_rise = sel && !rd_d_r && bus_r.rd_n;
    wire cmd_wr = wr_rise && bus_r.cmd_data_sel;
    wire dat_wr = wr_rise && !bus_r.cmd_data_sel;
    wire dat_rd = rd_rise && !bus_r.cmd_data_sel;
    wire [2:0] op = din_r[7:5];
    // configuration
    logic [2:0] kmode_r;
    logic [1:0] dmode_r;
    logic [4:0] pre_r;
    logic ai_r, rd_disp_r, ai_fifo_r;
    logic [3:0] daddr_r;
    logic [2:0] faddr_r;
    logic [1:0] iw_r, bl_r;
    logic blank_lvl_r;
    wire kds_pkg::kds_kmode_t km = kds_pkg::kds_kmode_t'(kmode_r[2:1]);
    wire encoded = !kmode_r[0];
    wire sixteen = dmode_r[0];
    wire keyb = !kmode_r[2];
    wire [4:0] pre_eff = (pre_r < `KDS_PRESCALE_MIN) ? `KDS_PRESCALE_MIN
        : pre_r;
    // clear command fields
    wire clr_cmd = cmd_wr && op == `KDS_CMD_CLEAR;
    wire clr_disp = clr_cmd && (din_r[4] || din_r[0]);
    wire clr_stat = clr_cmd && (din_r[1] || din_r[0]);
    wire [7:0] clr_val = !din_r[3] ? 8'h00
        : (din_r[2] ? 8'hff : `KDS_CLEAR_PAT);
    // display ram, contents survive reset
    logic [7:0] dram [16];
    logic [7:0] sram [8];
    logic [3:0] clr_cnt_r;
    logic clr_busy_r;
    // scan timing
    logic [4:0] pcnt_r;
    logic [3:0] scan_r;
    wire tick = pcnt_r >= pre_eff - 5'h01;
    wire [3:0] scan_max = sixteen ? 4'hf : 4'h7;
    // fifo
    logic [7:0] fifo [8];
    logic [2:0] wp_r, rp_r;
    logic [3:0] cnt_r;
    // one debounce counter per key, row by column
    logic [1:0] deb_r [64];
    function automatic logic [1:0] deb_step(input logic hit,
        input logic [1:0] cnt);
        return !hit ? 2'h0 : ((cnt == 2'h3) ? 2'h3 : cnt + 2'h1);
    endfunction : deb_step
    logic [7:0] keydn_r;
    logic irq_r, sens_int_r;
    wire [2:0] row = scan_r[2:0];
    wire [7:0] pressed = ~ret_r;
    logic [7:0] key_code;
    logic key_push;
    logic [2:0] key_col;
    always_comb begin
        key_push = 1'b0;
        key_col = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pressed[i] && !keydn_r[i] && deb_r[{row, 3'(i)}] == 2'h2) begin
                key_push = 1'b1;
                key_col = 3'(i);
            end
        end
        key_code = {ctl_r, shf_r, row, key_col};
    end
    wire lock_ok = km != kds_pkg::KDS_KEY_LOCK
        || ($countones(pressed) == 1);
    wire strobe_push = km == kds_pkg::KDS_STROBED && ctl_r && !ctl_d_r;
    wire push = strobe_push || (keyb && tick && key_push && lock_ok);
    wire [7:0] push_data = strobe_push ? ret_r : key_code;
    wire full = cnt_r == 4'(DEPTH);
    wire do_push = push && !full;
    wire fifo_rd = dat_rd && !rd_disp_r && km != kds_pkg::KDS_SENSOR;
    wire do_pop = fifo_rd && cnt_r != 4'h0;
    wire sens_chg = km == kds_pkg::KDS_SENSOR && tick
        && sram[row] != pressed;
    wire [3:0] wr_addr = clr_busy_r ? clr_cnt_r : daddr_r;
    always_ff @(posedge clk_sys) begin
        if (clr_busy_r) dram[clr_cnt_r] <= clr_val;
        else if (dat_wr) begin
            if (!iw_r[1]) dram[wr_addr][7:4] <= din_r[7:4];
            if (!iw_r[0]) dram[wr_addr][3:0] <= din_r[3:0];
        end
        if (do_push) fifo[wp_r] <= push_data;
        // sensor ram starts clean so the first compare is defined
        if (rst_r) begin
            for (int i = 0; i < 8; i++) sram[i] <= 8'h00;
        end else if (sens_chg) sram[row] <= pressed;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {wr_d_r, rd_d_r} <= 2'h3;
            kmode_r <= `KDS_KEYMODE_RST;
            dmode_r <= `KDS_DISPMODE_RST;
            pre_r <= `KDS_PRESCALE_RST;
            {ai_r, rd_disp_r, ai_fifo_r} <= 3'h0;
            daddr_r <= 4'h0;
            faddr_r <= 3'h0;
            {iw_r, bl_r, blank_lvl_r} <= 5'h00;
            {clr_busy_r, clr_cnt_r} <= 5'h00;
            {pcnt_r, scan_r} <= 9'h000;
            {wp_r, rp_r, cnt_r} <= 10'h000;
            keydn_r <= 8'h00;
            for (int i = 0; i < 64; i++) deb_r[i] <= 2'h0;
            {irq_r, sens_int_r, underrun_flag, overrun_flag} <= 4'h0;
        end else if (rst_r) begin
            {wr_d_r, rd_d_r} <= 2'h3;
            kmode_r <= `KDS_KEYMODE_RST;
            dmode_r <= `KDS_DISPMODE_RST;
            pre_r <= `KDS_PRESCALE_RST;
            {ai_r, rd_disp_r, ai_fifo_r} <= 3'h0;
            {pcnt_r, scan_r} <= 9'h000;
            {wp_r, rp_r, cnt_r} <= 10'h000;
            {iw_r, bl_r} <= 4'h0;
            {irq_r, sens_int_r, underrun_flag, overrun_flag} <= 4'h0;
        end else begin
            wr_d_r <= !sel || bus_r.wr_n;
            rd_d_r <= !sel || bus_r.rd_n;
            if (cmd_wr) begin
                unique case (op)
                    `KDS_CMD_MODE: {dmode_r, kmode_r} <= din_r[4:0];
                    `KDS_CMD_CLOCK: pre_r <= din_r[4:0];
                    `KDS_CMD_RDFIFO: begin
                        rd_disp_r <= 1'b0;
                        ai_fifo_r <= din_r[4];
                        faddr_r <= din_r[2:0];
                    end
                    `KDS_CMD_RDDISP: begin
                        rd_disp_r <= 1'b1;
                        ai_r <= din_r[4];
                        daddr_r <= din_r[3:0];
                    end
                    `KDS_CMD_WRDISP: begin
                        ai_r <= din_r[4];
                        daddr_r <= din_r[3:0];
                    end
                    `KDS_CMD_BLANK: {iw_r, bl_r} <= din_r[3:0];
                    `KDS_CMD_CLEAR: blank_lvl_r <= din_r[3] & din_r[2];
                    `KDS_CMD_ENDINT: sens_int_r <= 1'b0;
                endcase
            end
            if (clr_disp) {clr_busy_r, clr_cnt_r} <= 5'h10;
            else if (clr_busy_r) begin
                clr_cnt_r <= clr_cnt_r + 4'h1;
                clr_busy_r <= clr_cnt_r != 4'hf;
            end
            if ((dat_wr || (dat_rd && rd_disp_r)) && ai_r)
                daddr_r <= daddr_r + 4'h1;
            if (dat_rd && !rd_disp_r && km == kds_pkg::KDS_SENSOR) begin
                if (ai_fifo_r) faddr_r <= faddr_r + 3'h1;
                else sens_int_r <= 1'b0;
            end
            pcnt_r <= tick ? 5'h00 : pcnt_r + 5'h01;
            if (clr_cmd && din_r[0]) {pcnt_r, scan_r} <= 9'h000;
            else if (tick) scan_r <= (scan_r >= scan_max) ? 4'h0
                : scan_r + 4'h1;
            if (tick && keyb) begin
                for (int i = 0; i < 8; i++) begin
                    deb_r[{row, 3'(i)}] <= deb_step(pressed[i],
                        deb_r[{row, 3'(i)}]);
                end
                if (scan_r == scan_max) keydn_r <= 8'h00;
                if (key_push) keydn_r[key_col] <= 1'b1;
            end
            if (do_push) wp_r <= wp_r + 3'h1;
            if (do_pop) rp_r <= rp_r + 3'h1;
            cnt_r <= cnt_r + 4'(do_push) - 4'(do_pop);
            if (clr_stat) begin
                {wp_r, rp_r, cnt_r} <= 10'h000;
                {underrun_flag, overrun_flag, sens_int_r} <= 3'h0;
            end
            // a change in the same cycle as a clear wins
            if (sens_chg) sens_int_r <= 1'b1;
            if (fifo_rd && cnt_r == 4'h0) underrun_flag <= 1'b1;
            if (push && full) overrun_flag <= 1'b1;
            irq_r <= km == kds_pkg::KDS_SENSOR ? sens_int_r
                : (cnt_r != 4'h0 && !do_pop && !clr_stat);
        end
    end
    // display and host outputs
    wire [7:0] cur = dram[scan_r];
    wire switching = pcnt_r == 5'h00;
    wire [3:0] scan_nxt = encoded ? scan_r
        : (4'h1 << scan_r[1:0]);
    wire [3:0] bl_nib = {4{blank_lvl_r}};
    wire [7:0] rd_nxt = !bus_r.cmd_data_sel ? (rd_disp_r ? dram[daddr_r]
        : (km == kds_pkg::KDS_SENSOR ? sram[faddr_r] : fifo[rp_r]))
        : {clr_busy_r, sens_int_r, overrun_flag, underrun_flag, full,
           3'(cnt_r)};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            disp_out <= '0;
            {host_data_out, host_data_oe, irq_out} <= 10'h000;
        end else begin
            disp_out.scan_outputs <= rst_r ? 4'h0 : scan_nxt;
            disp_out.disp_nibble_a <= bl_r[1] ? bl_nib : cur[7:4];
            disp_out.disp_nibble_b <= bl_r[0] ? bl_nib : cur[3:0];
            disp_out.blank_display_n <= !(switching || &bl_r);
            host_data_oe <= sel && !bus_r.rd_n;
            host_data_out <= rd_nxt;
            irq_out <= irq_r;
        end
    end
    scan_low_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rst_r |=> disp_out.scan_outputs == 4'h0)
        else $error("scan outputs not low in reset");
    irq_pop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        do_pop && km != kds_pkg::KDS_SENSOR && !rst_r |=> ##1 !irq_out)
        else $error("interrupt did not drop on read");
    full_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        full && !do_pop && !clr_stat && !rst_r |=> full)
        else $error("full fifo lost entry");
    pre_min_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tick && !rst_r |-> pcnt_r >= 5'h01)
        else $error("prescale below two");
    deco_one_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !encoded && !rst_r |=> $countones(disp_out.scan_outputs) == 1)
        else $error("decoded scan not one hot");
    ovr_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        push && full && !rst_r |=> overrun_flag)
        else $error("overrun not flagged");
    oe_sel_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        host_data_oe |-> $past(sel))
        else $error("bus driven without select");
    rst_pre_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rst_r |=> pre_r == `KDS_PRESCALE_RST)
        else $error("prescale not reset");
endmodule : kds_scanner

// ---- kds_host_model.sv ----
// processor bus master model for the scanner
`timescale 1ns/1ns
module kds_host_model (
    input wire logic clk_sys,
    output kds_pkg::kds_bus_t bus_out,
    output logic [7:0] data_out,
    input wire logic [7:0] data_in
);
    initial begin
        bus_out = 4'hf;
        data_out = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask : tick
    // sel high picks command, low picks data
    task automatic wr(input logic cs, input logic sel,
        input logic [7:0] d);
        tick(1);
        bus_out = {~cs, 1'b1, 1'b0, sel};
        data_out = d;
        tick(4);
        bus_out.wr_n = 1'b1;
        tick(1);
        bus_out.cs_n = 1'b1;
        data_out = ~d;
        tick(4);
    endtask : wr
    task automatic rd(input logic sel, output logic [7:0] d);
        tick(1);
        bus_out = {1'b0, 1'b0, 1'b1, sel};
        tick(5);
        d = data_in;
        // select stays low past the read edge so the read is seen
        bus_out.rd_n = 1'b1;
        tick(1);
        bus_out.cs_n = 1'b1;
        tick(4);
    endtask : rd
endmodule : kds_host_model

// ---- keyboard_display_scanner_tb_top.sv ----
// self-checking bench for the keyboard display scanner
`timescale 1ns/1ns
module keyboard_display_scanner_tb_top;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic reset_in = 1'b1;
    logic shift_in = 1'b0;
    logic ctrl_strobe_in = 1'b0;
    logic key_on = 1'b0;
    logic seen_low = 1'b0;
    logic [7:0] strobe_byte = 8'hff;
    logic [2:0] key_row = 3'h0;
    logic [2:0] key_col = 3'h0;
    logic [7:0] rdat, host_data_out, host_data_in, return_lines;
    logic host_data_oe, irq_out, underrun_flag, overrun_flag;
    kds_pkg::kds_bus_t bus_in;
    kds_pkg::kds_disp_t disp_out;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    always #50 clk_sys = ~clk_sys;
    // key matrix pulls one return line low on its row
    assign return_lines = !key_on ? strobe_byte :
        (disp_out.scan_outputs[2:0] == key_row) ? ~(8'h01 << key_col) : 8'hff;
    kds_scanner #(.DEPTH(8)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .reset_in(reset_in),
        .bus_in(bus_in), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .return_lines(return_lines), .shift_in(shift_in),
        .ctrl_strobe_in(ctrl_strobe_in), .irq_out(irq_out),
        .disp_out(disp_out), .underrun_flag(underrun_flag),
        .overrun_flag(overrun_flag));
    kds_host_model host (.clk_sys(clk_sys), .bus_out(bus_in),
        .data_out(host_data_in), .data_in(host_data_out));
    always @(posedge clk_sys) begin
        cyc++;
        if (irq_out === 1'b0) seen_low <= 1'b1;
        if (cyc == 90000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic wait_scan(input logic [3:0] v, input int lim);
        for (int n = 0; n < lim && disp_out.scan_outputs !== v; n++)
            host.tick(1);
    endtask : wait_scan
    task automatic wait_irq(input int lim);
        for (int n = 0; n < lim && irq_out !== 1'b1; n++) host.tick(1);
    endtask : wait_irq
    task automatic cmd(input logic [7:0] d);
        host.wr(1'b1, 1'b1, d);
    endtask : cmd
    task automatic strobe(input logic [7:0] d);
        strobe_byte = d;
        host.tick(3);
        ctrl_strobe_in = 1'b1;
        host.tick(3);
        ctrl_strobe_in = 1'b0;
        host.tick(3);
    endtask : strobe
    task automatic t_reset;
        host.tick(3);
        arst_n = 1'b1;
        host.tick(4);
        chk("scan in reset", 8'h00, {4'h0, disp_out.scan_outputs});
        reset_in = 1'b0;
        host.tick(6);
        $display("test reset done");
    endtask : t_reset
    task automatic t_scan;
        int bad;
        bad = 0;
        cmd(8'h22);
        wait_scan(4'h9, 8000);
        chk("encoded count", 8'h09, {4'h0, disp_out.scan_outputs});
        cmd(8'h09);
        host.tick(20);
        repeat (400) begin
            host.tick(1);
            if (!$onehot(disp_out.scan_outputs)) bad++;
        end
        chk("decoded scan", 8'h00, 8'(bad));
        $display("test scan done");
    endtask : t_scan
    task automatic t_strobe;
        cmd(8'h0e);
        cmd(8'h40);
        shift_in = 1'b1;
        strobe(8'ha5);
        strobe(8'h3c);
        wait_irq(200);
        chk("irq with data", 8'h01, {7'h0, irq_out});
        seen_low = 1'b0;
        host.rd(1'b0, rdat);
        chk("first byte", 8'ha5, rdat);
        host.tick(6);
        chk("irq dip", 8'h03, {6'h0, seen_low, irq_out});
        host.rd(1'b0, rdat);
        chk("second byte", 8'h3c, rdat);
        host.tick(6);
        chk("irq drained", 8'h00, {7'h0, irq_out});
        for (int i = 0; i < 9; i++) strobe(8'h10 + 8'(i));
        chk("overrun", 8'h01, {7'h0, overrun_flag});
        host.rd(1'b1, rdat);
        chk("status full", 8'h28, rdat);
        for (int i = 0; i < 8; i++) begin
            host.rd(1'b0, rdat);
            chk("fifo entry", 8'h10 + 8'(i), rdat);
        end
        host.rd(1'b0, rdat);
        chk("underrun", 8'h01, {7'h0, underrun_flag});
        cmd(8'hc2);
        chk("flags clear", 8'h00, {6'h0, overrun_flag, underrun_flag});
        strobe_byte = 8'hff;
        $display("test strobed fifo done");
    endtask : t_strobe
    task automatic t_disp;
        cmd(8'h90);
        for (int i = 0; i < 4; i++) host.wr(1'b1, 1'b0, 8'h30 + 8'(i));
        cmd(8'h81);
        host.wr(1'b0, 1'b0, 8'hff);
        cmd(8'h70);
        for (int i = 0; i < 4; i++) begin
            host.rd(1'b0, rdat);
            chk("display byte", 8'h30 + 8'(i), rdat);
        end
        wait_scan(4'h1, 8000);
        chk("nibble ports", 8'h31,
            {disp_out.disp_nibble_a, disp_out.disp_nibble_b});
        $display("test display done");
    endtask : t_disp
    task automatic t_blank;
        int lows;
        lows = 0;
        cmd(8'ha2);
        chk("nibble a blank", 8'h00, {4'h0, disp_out.disp_nibble_a});
        cmd(8'hcc);
        cmd(8'ha3);
        repeat (20) begin
            host.tick(1);
            if (disp_out.blank_display_n === 1'b0) lows++;
        end
        chk("blank forced", 8'h14, 8'(lows));
        chk("both blank", 8'hff,
            {disp_out.disp_nibble_a, disp_out.disp_nibble_b});
        cmd(8'ha0);
        cmd(8'hc0);
        lows = 0;
        repeat (20) begin
            host.tick(1);
            if (disp_out.blank_display_n === 1'b0) lows++;
        end
        chk("blank on switch", 8'h01, {7'h0, (lows > 0 && lows < 20)});
        $display("test blank done");
    endtask : t_blank
    task automatic t_sensor;
        cmd(8'h0c);
        key_row = 3'h3;
        key_col = 3'h5;
        key_on = 1'b1;
        wait_irq(4000);
        chk("sensor irq", 8'h01, {7'h0, irq_out});
        cmd(8'h43);
        host.rd(1'b0, rdat);
        chk("sensor row", 8'h20, rdat);
        host.tick(4);
        chk("sensor irq read", 8'h00, {7'h0, irq_out});
        key_on = 1'b0;
        wait_irq(4000);
        chk("release irq", 8'h01, {7'h0, irq_out});
        cmd(8'he0);
        chk("end interrupt", 8'h00, {7'h0, irq_out});
        $display("test sensor done");
    endtask : t_sensor
    task automatic t_key(input logic c, input logic s, input logic [2:0] r,
        input logic [2:0] k);
        cmd(8'h40);
        ctrl_strobe_in = c;
        shift_in = s;
        key_row = r;
        key_col = k;
        key_on = 1'b1;
        wait_irq(20000);
        key_on = 1'b0;
        host.rd(1'b0, rdat);
        chk("key code", {c, s, r, k}, rdat);
        for (int i = 0; i < 3; i++) begin
            wait_scan(4'hf, 8000);
            wait_scan(4'h0, 8000);
        end
        $display("test key done");
    endtask : t_key
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        t_reset();
        t_scan();
        t_strobe();
        cmd(8'h08);
        t_disp();
        t_blank();
        cmd(8'h3f);
        t_sensor();
        cmd(8'h08);
        t_key(1'b0, 1'b1, 3'h3, 3'h5);
        t_key(1'b1, 1'b0, 3'h6, 3'h2);
        wrap_up();
    end
endmodule : keyboard_display_scanner_tb_top
